// File: hdl/awd_top.v
// area wait-state register bank with access stretcher
//
// Overview of operation
// RULE1: area5 first wait code gives 0,1,2,3,6,9,12,15 waits; reset 15.
// RULE2: area5 burst pitch gives 0..7 later-beat waits; wait input off at 0.
// RULE3: area4 code gives table waits; wait input ignored only at code 0.
// RULE4: bits 16 and 12 read zero; software writes zero there.
// RULE5: area3 static memory decodes table waits; wait input off at 0.
// RULE6: area3 wait input only for static or multiplexed, never DRAM kinds.
// RULE7: area3 DRAM holds column strobe 1,2,3,4,7,10,13,16 cycles.
// RULE8: area3 SDRAM latency 1..5 for codes 1..5; other codes forbidden.
// RULE9: software avoids area3 latency 1,4,5 in row-held-down operation.
// RULE10: area2 static memory decodes table waits; wait input off at 0.
// RULE11: area2 wait input only static or multiplexed, never SDRAM.
// RULE12: area2 SDRAM latency 1..5 for codes 1..5; other codes forbidden.
// RULE13: software avoids area2 latency 1,4,5 in row-held-down operation.
// RULE14: multiplexed areas reinterpret field: read 1,1,2,3, write 0..3.
// RULE15: access stretched by selected area waits plus external waits.
//
// Implementation choices: the placing of the registers and the AXI4-Lite register port.
`timescale 1ns/1ps
`include "awd_consts.vh"

module awd_top #(
  parameter ADDR_W = 12
) (
  input wire clk,
  input wire rst_b,
  input wire [ADDR_W-1:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [ADDR_W-1:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  input wire acc_start,
  input wire [2:0] acc_area,
  input wire acc_write,
  input wire acc_later_beat,
  input wire ext_wait_req,
  output wire acc_busy,
  output wire acc_done,
  output reg acc_ext_wait_en_q,
  output reg [4:0] dram_cas_width_q,
  output reg [2:0] sdram_cas_lat_q,
  output reg sdram_lat_ok_q
);

  // ************************************************************
  // helper functions
  // ************************************************************

  // merge write data into a word under byte strobes
  function [31:0] wmerge;
    input [31:0] old;
    input [31:0] data;
    input [3:0] strb;
    integer i;
    begin
      wmerge = old;
      for (i = 0; i < 4; i = i + 1) begin
        if (strb[i]) begin
          wmerge[i*8 +: 8] = data[i*8 +: 8];
        end
      end
    end
  endfunction

  // word-aligned offset of a bus address
  function [11:0] word_ofs;
    input [ADDR_W-1:0] a;
    begin
      word_ofs = {a[11:2], 2'b00};
    end
  endfunction

  // ************************************************************
  // registers
  // ************************************************************
  reg [31:0] wait_ctl_q;
  reg [6:0] if_cfg_q;

  // write channel holding state
  reg aw_hold_q;
  reg [ADDR_W-1:0] awaddr_q;
  reg w_hold_q;
  reg [31:0] wdata_q;
  reg [3:0] wstrb_q;

  // external wait input synchroniser and filter
  reg ext_s1_q;
  reg ext_s2_q;
  reg ext_s3_q;
  reg ext_lvl_q;

  // ************************************************************
  // write address and data capture
  // ************************************************************
  assign s_axi_awready = !aw_hold_q && !s_axi_bvalid;
  assign s_axi_wready = !w_hold_q && !s_axi_bvalid;

  wire do_write;
  wire [11:0] wr_ofs;
  assign do_write = aw_hold_q && w_hold_q && !s_axi_bvalid;
  assign wr_ofs = word_ofs(awaddr_q);

  // channels taken in either order, held until the write is done
  always @(posedge clk) begin
    if (!rst_b) begin
      aw_hold_q <= 1'b0;
      awaddr_q <= {ADDR_W{1'b0}};
      w_hold_q <= 1'b0;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold_q <= 1'b1;
        awaddr_q <= s_axi_awaddr;
      end else if (do_write) begin
        aw_hold_q <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold_q <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end else if (do_write) begin
        w_hold_q <= 1'b0;
      end
    end
  end

  // ************************************************************
  // register update and write response
  // ************************************************************
  always @(posedge clk) begin
    if (!rst_b) begin
      wait_ctl_q <= `AWD_WAIT_RST;
      if_cfg_q <= `AWD_IFCFG_RST;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `AWD_RESP_OKAY;
    end else begin
      if (do_write) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= `AWD_RESP_OKAY;
        case (wr_ofs)
          `AWD_OFS_WAIT: begin
            // RULE4: reserved bits kept zero
            wait_ctl_q <= wmerge(wait_ctl_q, wdata_q, wstrb_q) &
                          ~`AWD_WAIT_RSV;
          end
          `AWD_OFS_IFCFG: begin
            if (wstrb_q[0]) begin
              if_cfg_q <= wdata_q[6:0];
            end
          end
          `AWD_OFS_STAT: begin
            s_axi_bresp <= `AWD_RESP_OKAY; // read-only, write dropped
          end
          default: begin
            s_axi_bresp <= `AWD_RESP_SLVERR;
          end
        endcase
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // ************************************************************
  // external wait input: three flops, change when 2nd and 3rd agree
  // ************************************************************
  always @(posedge clk) begin
    if (!rst_b) begin
      ext_s1_q <= 1'b0;
      ext_s2_q <= 1'b0;
      ext_s3_q <= 1'b0;
      ext_lvl_q <= 1'b0;
    end else begin
      ext_s1_q <= ext_wait_req;
      ext_s2_q <= ext_s1_q;
      ext_s3_q <= ext_s2_q;
      if (ext_s2_q == ext_s3_q) begin
        ext_lvl_q <= ext_s3_q;
      end
    end
  end

  // ************************************************************
  // area selection
  // ************************************************************
  wire [1:0] a3_mode;
  wire [1:0] a2_mode;
  assign a3_mode = if_cfg_q[`AWD_CFG_A3_MODE_LSB +: 2];
  assign a2_mode = if_cfg_q[`AWD_CFG_A2_MODE_LSB +: 2];

  reg [2:0] sel_code;
  reg [2:0] sel_pitch;
  reg [1:0] sel_mode;
  reg sel_use_pitch;
  reg sel_mapped;

  // pick the field of the addressed area
  always @* begin
    sel_code = 3'h0;
    sel_pitch = 3'h0;
    sel_mode = `AWD_MODE_SRAM;
    sel_use_pitch = 1'b0;
    sel_mapped = 1'b1;
    case (acc_area)
      `AWD_AREA5: begin
        // RULE1: area5 first wait field
        sel_code = wait_ctl_q[`AWD_A5_WAIT_LSB +: 3];
        sel_pitch = wait_ctl_q[`AWD_A5_PITCH_LSB +: 3];
        sel_mode = if_cfg_q[`AWD_CFG_A5_MPX_BIT] ?
                   `AWD_MODE_MPX : `AWD_MODE_SRAM;
        // RULE2: pitch on later burst beats
        sel_use_pitch = if_cfg_q[`AWD_CFG_A5_BROM_BIT] && acc_later_beat;
      end
      `AWD_AREA4: begin
        // RULE3: area4 wait field
        sel_code = wait_ctl_q[`AWD_A4_WAIT_LSB +: 3];
        sel_mode = if_cfg_q[`AWD_CFG_A4_MPX_BIT] ?
                   `AWD_MODE_MPX : `AWD_MODE_SRAM;
      end
      `AWD_AREA3: begin
        // RULE5: area3 wait field
        sel_code = wait_ctl_q[`AWD_A3_WAIT_LSB +: 3];
        sel_mode = a3_mode;
      end
      `AWD_AREA2: begin
        // RULE10: area2 wait field
        sel_code = wait_ctl_q[`AWD_A2_WAIT_LSB +: 3];
        // area 2 has no plain DRAM kind; treat it as static memory
        sel_mode = (a2_mode == `AWD_MODE_DRAM) ? `AWD_MODE_SRAM : a2_mode;
      end
      default: begin
        sel_mapped = 1'b0;
      end
    endcase
  end

  // ************************************************************
  // decode and stretch
  // ************************************************************
  wire [4:0] dec_wait;
  wire dec_rdy_en;
  wire [4:0] dec_cas_width;
  wire [2:0] dec_cas_lat;
  wire dec_lat_ok;
  wire gated_rdy_en;
  wire [7:0] ext_cnt;

  awd_wait_decode u_decode (
    .code(sel_code),
    .pitch(sel_pitch),
    .mode(sel_mode),
    .is_write(acc_write),
    .later_beat(acc_later_beat),
    .use_pitch(sel_use_pitch),
    .wait_cnt(dec_wait),
    .rdy_en(dec_rdy_en),
    .cas_width(dec_cas_width),
    .cas_lat(dec_cas_lat),
    .lat_ok(dec_lat_ok)
  );

  // RULE6: DRAM kinds ignore the wait input
  // RULE11: SDRAM ignores the wait input
  assign gated_rdy_en = dec_rdy_en && sel_mapped;

  awd_wait_timer u_timer (
    .clk(clk),
    .rst_b(rst_b),
    .start(acc_start),
    .load_cnt(sel_mapped ? dec_wait : 5'h00),
    .rdy_en(gated_rdy_en),
    .ext_wait(ext_lvl_q),
    .busy_q(acc_busy),
    .done_q(acc_done),
    .ext_cnt_q(ext_cnt)
  );

  // latch the decoded memory timing at access start
  always @(posedge clk) begin
    if (!rst_b) begin
      acc_ext_wait_en_q <= 1'b0;
      dram_cas_width_q <= 5'h00;
      sdram_cas_lat_q <= 3'h0;
      sdram_lat_ok_q <= 1'b0;
    end else if (acc_start && !acc_busy) begin
      acc_ext_wait_en_q <= gated_rdy_en;
      // RULE7: column strobe width
      dram_cas_width_q <= sel_mapped ? dec_cas_width : 5'h00;
      // RULE8: area3 latency select
      // RULE12: area2 latency select
      sdram_cas_lat_q <= sel_mapped ? dec_cas_lat : 3'h0;
      sdram_lat_ok_q <= dec_lat_ok && sel_mapped;
    end
  end

  // ************************************************************
  // read channel
  // ************************************************************
  assign s_axi_arready = !s_axi_rvalid;

  wire [31:0] stat_word;
  assign stat_word = {16'h0000, ext_cnt, 4'h0, sdram_lat_ok_q,
                      ext_lvl_q, acc_busy, acc_ext_wait_en_q};

  // one read at a time, data registered
  always @(posedge clk) begin
    if (!rst_b) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `AWD_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= `AWD_RESP_OKAY;
      case (word_ofs(s_axi_araddr))
        `AWD_OFS_WAIT: begin
          // RULE4: reserved bits read zero
          s_axi_rdata <= wait_ctl_q & ~`AWD_WAIT_RSV;
        end
        `AWD_OFS_IFCFG: begin
          s_axi_rdata <= {25'h000_0000, if_cfg_q};
        end
        `AWD_OFS_STAT: begin
          s_axi_rdata <= stat_word;
        end
        default: begin
          s_axi_rdata <= 32'h0000_0000;
          s_axi_rresp <= `AWD_RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule // awd_top

// File: hdl/awd_wait_decode.v
// field decoder: wait count, wait-input enable, cas width and latency
`timescale 1ns/1ps
`include "awd_consts.vh"

module awd_wait_decode (
  input wire [2:0] code,
  input wire [2:0] pitch,
  input wire [1:0] mode,
  input wire is_write,
  input wire later_beat,
  input wire use_pitch,
  output reg [4:0] wait_cnt,
  output reg rdy_en,
  output reg [4:0] cas_width,
  output reg [2:0] cas_lat,
  output reg lat_ok
);

  // codes 0..3 map straight, 4..7 map to 6, 9, 12, 15
  function [4:0] wait_of;
    input [2:0] c;
    begin
      if (c[2]) begin
        wait_of = 5'h06 + {2'b00, c[1:0], 1'b0} + {3'b000, c[1:0]};
      end else begin
        wait_of = {3'b000, c[1:0]};
      end
    end
  endfunction

  // per-mode interpretation of the selected field
  always @* begin
    wait_cnt = 5'h00;
    rdy_en = 1'b0;
    cas_width = 5'h00;
    cas_lat = 3'h0;
    lat_ok = 1'b0;
    case (mode)
      `AWD_MODE_MPX: begin
        // RULE14: multiplexed reinterpretation
        rdy_en = 1'b1;
        if (later_beat) begin
          wait_cnt = {4'h0, code[2]};
        end else if (is_write) begin
          wait_cnt = {3'b000, code[1:0]};
        end else if (code[1:0] == 2'b00) begin
          wait_cnt = 5'h01;
        end else begin
          wait_cnt = {3'b000, code[1:0]};
        end
      end
      `AWD_MODE_DRAM: begin
        // RULE7: cas width one above wait
        cas_width = wait_of(code) + 5'h01;
      end
      `AWD_MODE_SDRAM: begin
        // RULE8: latency codes one to five
        lat_ok = (code != 3'h0) && (code <= 3'h5);
        cas_lat = lat_ok ? code : 3'h0;
      end
      default: begin
        if (use_pitch) begin
          // RULE2: burst pitch binary
          wait_cnt = {2'b00, pitch};
          rdy_en = (pitch != 3'h0);
        end else begin
          // RULE1: first-cycle wait table
          wait_cnt = wait_of(code);
          rdy_en = (code != 3'h0);
        end
      end
    endcase
  end

endmodule // awd_wait_decode

// File: hdl/awd_wait_timer.v
// access stretcher: programmed waits then external waits
`timescale 1ns/1ps

module awd_wait_timer (
  input wire clk,
  input wire rst_b,
  input wire start,
  input wire [4:0] load_cnt,
  input wire rdy_en,
  input wire ext_wait,
  output reg busy_q,
  output reg done_q,
  output reg [7:0] ext_cnt_q
);

  localparam [1:0] ST_IDLE = 2'b00;
  localparam [1:0] ST_PROG = 2'b01;
  localparam [1:0] ST_EXT = 2'b10;

  reg [1:0] state_q;
  reg [4:0] cnt_q;
  reg rdy_en_q;

  // RULE15: programmed plus external waits
  always @(posedge clk) begin
    if (!rst_b) begin
      state_q <= ST_IDLE;
      cnt_q <= 5'h00;
      rdy_en_q <= 1'b0;
      busy_q <= 1'b0;
      done_q <= 1'b0;
      ext_cnt_q <= 8'h00;
    end else begin
      done_q <= 1'b0;
      case (state_q)
        ST_IDLE: begin
          if (start) begin
            state_q <= ST_PROG;
            cnt_q <= load_cnt;
            rdy_en_q <= rdy_en;
            busy_q <= 1'b1;
            ext_cnt_q <= 8'h00;
          end
        end
        ST_PROG: begin
          if (cnt_q != 5'h00) begin
            cnt_q <= cnt_q - 5'h01;
          end else if (rdy_en_q && ext_wait) begin
            state_q <= ST_EXT;
            ext_cnt_q <= 8'h01;
          end else begin
            state_q <= ST_IDLE;
            busy_q <= 1'b0;
            done_q <= 1'b1;
          end
        end
        ST_EXT: begin
          if (ext_wait) begin
            if (ext_cnt_q != 8'hFF) begin
              ext_cnt_q <= ext_cnt_q + 8'h01; // saturating
            end
          end else begin
            state_q <= ST_IDLE;
            busy_q <= 1'b0;
            done_q <= 1'b1;
          end
        end
        default: begin
          state_q <= ST_IDLE;
          busy_q <= 1'b0;
        end
      endcase
    end
  end

endmodule // awd_wait_timer

// File: include/awd_consts.vh
// constants for the area wait-state decode block
`ifndef AWD_CONSTS_VH
`define AWD_CONSTS_VH

// ************************************************************
// register byte offsets
// ************************************************************
`define AWD_OFS_WAIT 12'h000
`define AWD_OFS_IFCFG 12'h004
`define AWD_OFS_STAT 12'h008

// ************************************************************
// reset values and reserved bits
// ************************************************************
`define AWD_WAIT_RST 32'hFFFE_EFFF
`define AWD_WAIT_RSV 32'h0001_1000
`define AWD_IFCFG_RST 7'h00

// ************************************************************
// wait register field positions (low bit of each 3-bit field)
// ************************************************************
`define AWD_A5_WAIT_LSB 23
`define AWD_A5_PITCH_LSB 20
`define AWD_A4_WAIT_LSB 17
`define AWD_A3_WAIT_LSB 13
`define AWD_A2_WAIT_LSB 9

// ************************************************************
// interface config field positions
// ************************************************************
`define AWD_CFG_A3_MODE_LSB 0
`define AWD_CFG_A2_MODE_LSB 2
`define AWD_CFG_A4_MPX_BIT 4
`define AWD_CFG_A5_MPX_BIT 5
`define AWD_CFG_A5_BROM_BIT 6

// ************************************************************
// memory interface kinds
// ************************************************************
`define AWD_MODE_SRAM 2'h0
`define AWD_MODE_DRAM 2'h1
`define AWD_MODE_SDRAM 2'h2
`define AWD_MODE_MPX 2'h3

// ************************************************************
// area numbers and bus answers
// ************************************************************
`define AWD_AREA2 3'h2
`define AWD_AREA3 3'h3
`define AWD_AREA4 3'h4
`define AWD_AREA5 3'h5
`define AWD_RESP_OKAY 2'h0
`define AWD_RESP_SLVERR 2'h2

`endif

// File: testbench/awd_chk_sva.sv
// checker: port-level assertions for the area wait decode top
`timescale 1ns/1ps
module awd_chk #(
  parameter ADDR_W = 12
) (
  input wire clk,
  input wire rst_b,
  input wire [ADDR_W-1:0] s_axi_araddr,
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire [31:0] s_axi_rdata,
  input wire [1:0] s_axi_rresp,
  input wire s_axi_rvalid,
  input wire [1:0] s_axi_bresp,
  input wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire acc_start,
  input wire [2:0] acc_area,
  input wire acc_busy,
  input wire acc_done,
  input wire acc_ext_wait_en_q,
  input wire [4:0] dram_cas_width_q,
  input wire [2:0] sdram_cas_lat_q,
  input wire sdram_lat_ok_q
);
  reg [ADDR_W-1:0] rd_addr_q;
  wire take = acc_start && !acc_busy;
  // ************************************************************
  // helper: offset of the last taken read
  // ************************************************************
  always @(posedge clk) begin
    if (!rst_b) begin
      rd_addr_q <= {ADDR_W{1'b0}};
    end else if (s_axi_arvalid && s_axi_arready) begin
      rd_addr_q <= s_axi_araddr;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  // ************************************************************
  // register bus
  // ************************************************************
  // reserved bits zero
  a_rsv_read_zero: assert property (
    s_axi_rvalid && rd_addr_q == 0 |-> !s_axi_rdata[16] && !s_axi_rdata[12])
    else $error("reserved wait bit reads one");
  a_unmapped_err: assert property (
    s_axi_rvalid && rd_addr_q >= 12'h00c |-> s_axi_rresp == 2'h2
    && s_axi_rdata == 32'h0000_0000) else $error("unmapped read not refused");
  a_read_answer: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer missing");
  a_bresp_hold: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  // ************************************************************
  // access stretcher and decode
  // ************************************************************
  // access begins busy
  a_start_busy: assert property (
    take |=> acc_busy) else $error("access not busy");
  a_done_pulse: assert property (
    acc_done |=> !acc_done) else $error("done longer than one cycle");
  a_done_ends_busy: assert property (
    acc_done |-> !acc_busy && $past(acc_busy)) else $error("done without busy");
  a_lat_pairing: assert property (
    sdram_lat_ok_q == (sdram_cas_lat_q inside {[1:5]}))
    else $error("latency flag mismatch");
  a_cas_area3: assert property (
    take && acc_area != 3'h3 |=> dram_cas_width_q == 5'h00)
    else $error("strobe width outside area3");
  a_odd_area_off: assert property (
    take && !(acc_area inside {[2:5]}) |=> !acc_ext_wait_en_q
    && !sdram_lat_ok_q) else $error("foreign area decoded");
endmodule // awd_chk
bind awd_top awd_chk #(.ADDR_W(ADDR_W)) u_chk (.*);

// File: testbench/awd_mem_model.sv
// far-side memory model: drives the external wait request
`timescale 1ns/1ps
module awd_mem_model (
  input wire clk,
  input wire rst_b,
  input wire acc_start,
  input wire [7:0] hold,
  output wire ext_wait_req
);
  reg [7:0] cnt_q;
  // slow memory wait
  // load the wait length at each access start, then count down
  always @(posedge clk) begin
    if (!rst_b) begin
      cnt_q <= 8'h00;
    end else if (acc_start) begin
      cnt_q <= hold;
    end else if (cnt_q != 8'h00) begin
      cnt_q <= cnt_q - 8'h01;
    end
  end
  // released line falls to its pulled-down idle level
  assign ext_wait_req = (cnt_q != 8'h00);
endmodule // awd_mem_model

// File: testbench/awd_tb_top.sv
// self-checking bench for the area wait decode block
`timescale 1ns/1ps
module awd_tb_top;
  reg clk = 1'b0;
  reg rst_b = 1'b0;
  reg [11:0] s_axi_awaddr = 12'h000;
  reg [11:0] s_axi_araddr = 12'h000;
  reg [31:0] s_axi_wdata = 32'h0000_0000;
  reg [3:0] s_axi_wstrb = 4'h0;
  reg s_axi_awvalid = 1'b0;
  reg s_axi_wvalid = 1'b0;
  reg s_axi_bready = 1'b0;
  reg s_axi_arvalid = 1'b0;
  reg s_axi_rready = 1'b0;
  reg acc_start = 1'b0;
  reg acc_write = 1'b0;
  reg acc_later_beat = 1'b0;
  reg [2:0] acc_area = 3'h0;
  reg [7:0] hold = 8'h00;
  wire ext_wait_req, s_axi_awready, s_axi_wready, s_axi_bvalid;
  wire s_axi_arready, s_axi_rvalid, acc_busy, acc_done;
  wire acc_ext_wait_en_q, sdram_lat_ok_q;
  wire [1:0] s_axi_bresp;
  wire [1:0] s_axi_rresp;
  wire [31:0] s_axi_rdata;
  wire [4:0] dram_cas_width_q;
  wire [2:0] sdram_cas_lat_q;
  integer failures = 0;
  integer checked = 0;
  integer cyc = 0;
  integer c, k, j, n, e;
  reg [31:0] v, rd, rr;
  localparam [39:0] WT = {5'h0f, 5'h0c, 5'h09, 5'h06,
    5'h03, 5'h02, 5'h01, 5'h00};
  localparam [39:0] DW = {5'h10, 5'h0d, 5'h0a, 5'h07,
    5'h04, 5'h03, 5'h02, 5'h01};

  awd_top uut (.*);
  awd_mem_model u_mem (.clk(clk), .rst_b(rst_b), .acc_start(acc_start),
    .hold(hold), .ext_wait_req(ext_wait_req));

  // ************************************************************
  // clock, timeout and helpers
  // ************************************************************
  always #12.5 clk = ~clk;
  // cut a hang short
  always @(posedge clk) begin
    cyc = cyc + 1;
    if (cyc == 40000) begin
      failures = failures + 1;
      close_out;
    end
  end
  function integer pos(input integer a);
    begin
      pos = (a == 5) ? 23 : (a == 4) ? 17 : (a == 3) ? 13 : 9;
    end
  endfunction
  task chk(input [31:0] seen, input [31:0] exp);
    begin
      checked = checked + 1;
      if (seen !== exp) begin
        failures = failures + 1;
        $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
    end
  endtask
  task wr(input [11:0] a, input [31:0] d);
    reg aw, w;
    begin
      @(posedge clk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_wstrb <= 4'hf;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      aw = 0;
      w = 0;
      while (!(aw && w)) begin
        @(posedge clk);
        aw = aw | s_axi_awready;
        w = w | s_axi_wready;
        s_axi_awvalid <= !aw;
        s_axi_wvalid <= !w;
      end
      do @(posedge clk); while (!s_axi_bvalid);
      s_axi_bready <= 1'b1; // answer left standing one cycle
      @(posedge clk);
      rr = s_axi_bresp;
      s_axi_bready <= 1'b0;
    end
  endtask
  task rd_reg(input [11:0] a);
    begin
      @(posedge clk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do @(posedge clk); while (!s_axi_arready);
      s_axi_arvalid <= 1'b0;
      do @(posedge clk); while (!s_axi_rvalid);
      rd = s_axi_rdata;
      rr = s_axi_rresp;
      s_axi_rready <= 1'b0;
    end
  endtask
  // one external access; n counts edges from start to done
  task acc(input [2:0] ar, input wk, input lb);
    begin
      @(posedge clk);
      acc_area <= ar;
      acc_write <= wk;
      acc_later_beat <= lb;
      acc_start <= 1'b1;
      @(posedge clk);
      acc_start <= 1'b0;
      n = 0;
      do begin
        @(posedge clk);
        #1;
        n = n + 1;
      end while (!acc_done && n < 300);
    end
  endtask
  task close_out;
    begin
      $display("checked %0d failures %0d", checked, failures);
      if (failures == 0 && checked > 0) begin
        $display("ALL TESTS PASSED");
      end else begin
        $display("TESTS FAILED");
      end
      $finish;
    end
  endtask

  // ************************************************************
  // test sequence
  // ************************************************************
  initial begin
    repeat (4) @(posedge clk);
    rst_b <= 1'b1;
    rd_reg(12'h000);
    chk(rd, 32'hfffe_efff);
    acc(3'h5, 1'b0, 1'b0);
    chk(n, 16);
    rd_reg(12'h00c);
    chk(rr, 32'h0000_0002);
    chk(rd, 32'h0000_0000);
    wr(12'h00c, 32'h0000_0001);
    chk(rr, 2);
    wr(12'h000, 32'hffff_ffff);
    rd_reg(12'h000);
    chk(rd, 32'hfffe_efff);
    acc(3'h6, 1'b0, 1'b0);
    chk(n, 1);
    $display("test reset and map done");
    wr(12'h004, 32'h0000_0000);
    for (c = 0; c < 8; c = c + 1) begin
      v = c << 20;
      for (k = 2; k < 6; k = k + 1) v = v | (((c + k) % 8) << pos(k));
      wr(12'h000, v);
      rd_reg(12'h000);
      chk(rd, v);
      for (k = 2; k < 6; k = k + 1) begin
        e = (c + k) % 8;
        acc(k[2:0], 1'b0, 1'b0);
        chk(n, WT[e*5+:5] + 1);
        chk(acc_ext_wait_en_q, e != 0);
      end
    end
    $display("test static tables done");
    wr(12'h004, 32'h0000_0040);
    for (c = 0; c < 8; c = c + 1) begin
      wr(12'h000, c << 20);
      acc(3'h5, 1'b0, 1'b1);
      chk(n, c + 1);
      chk(acc_ext_wait_en_q, c != 0);
    end
    $display("test burst pitch done");
    for (c = 0; c < 8; c = c + 1) begin
      wr(12'h000, (c << 13) | (c << 9));
      for (j = 0; j < 3; j = j + 1) begin
        wr(12'h004, (j == 2) ? 8 : j + 1);
        acc((j == 2) ? 3'h2 : 3'h3, 1'b0, 1'b0);
        chk(n, 1);
        chk(acc_ext_wait_en_q, 0);
        chk(dram_cas_width_q, (j == 0) ? DW[c*5+:5] : 0);
        e = (j > 0 && c > 0 && c < 6) ? c : 0;
        chk(sdram_cas_lat_q, e);
        chk(sdram_lat_ok_q, e != 0);
      end
    end
    $display("test dram kinds done");
    wr(12'h004, 32'h0000_003f);
    rd_reg(12'h004);
    chk(rd, 32'h0000_003f);
    for (c = 0; c < 8; c = c + 1) begin
      wr(12'h000, (c << 23) | (c << 17) | (c << 13) | (c << 9));
      for (k = 2; k < 6; k = k + 1) begin
        for (j = 0; j < 3; j = j + 1) begin
          acc(k[2:0], j == 1, j == 2);
          e = (j == 2) ? c / 4 : (j == 0 && c % 4 == 0) ? 1 : c % 4;
          chk(n, e + 1);
          chk(acc_ext_wait_en_q, 1);
        end
      end
    end
    $display("test multiplexed done");
    wr(12'h004, 32'h0000_0000);
    wr(12'h000, 32'h000c_0000);
    @(posedge clk);
    hold <= 8'h14;
    acc(3'h4, 1'b0, 1'b0);
    chk(n > 17 && n < 30, 1);
    e = n - 13; // cycles beyond 12 programmed waits and the done edge
    rd_reg(12'h008);
    chk(rd, (e << 8) | 32'h0000_0001);
    repeat (30) @(posedge clk);
    wr(12'h000, 32'h0000_0000);
    acc(3'h4, 1'b0, 1'b0);
    chk(n, 1);
    $display("test external wait done");
    close_out;
  end
endmodule // awd_tb_top
